// [rtl/dcmsr_regs.sv]
// Mode, termination-mask and status register bank of the disk unit, with its byte buffer
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Mode bit 4 selects FM, else MFM
// - FM doubles step period and pulse width
// - Step rates scale from clock; 000 fastest
// - Mask bit 7 presets CRC ones or zeros
// - CRC accumulation starts at first A1 byte
// - Done/ready-change interrupts gated by mask bits 5,1
// - Deleted mark or user input ends after sector
// - Write protect ends write/format immediately
// - Write fault sets done, ends after sector
// - Data register moves DMA bytes, holds head delay
// - Reading interrupt flags drops interrupt output
// - Pending bit sets on done/ready change, read clears
// - Ready line edge sets ready-change, read clears
// - DMA request bit until byte moved
// - Unacknowledged DMA sets overrun flag
// - Done sets at completion, clears on command
// - Termination code 00/01/10/11 meaning
// - Retry, correction, CRC, deleted-mark status bits
// - Sync or compare error ends command
// - ID sync loads head/cylinder capture bytes
// - Step periods double per code from 001 to 111, 0.2 ms to 12.8 ms on hard disk MFM
// - Reset pin or command idles outputs
module dcmsr_regs
    import dcmsr_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rst_n_pin,
    // Host bus
    input wire logic cmd_sel,
    input wire logic rd_wr,
    input wire logic bus_strobe_n,
    input wire logic [7:0] host_bus_lines_in,
    output logic [7:0] host_bus_lines_out,
    output logic host_bus_lines_oe_n,
    output logic int_out,
    // Register pointer from the command sequencer
    input wire logic ptr_load,
    input wire logic [3:0] ptr_value,
    // Sequencer events
    input wire logic cmd_done,
    input wire logic [1:0] term_code,
    input wire logic retry_evt,
    input wire logic ecc_fix_evt,
    input wire logic crc_err_evt,
    input wire logic ddm_seen,
    input wire logic sync_err_evt,
    input wire logic cmp_err_evt,
    input wire logic sector_end,
    input wire logic write_cmd,
    input wire logic reset_cmd,
    input wire logic [1:0] drive_num,
    // ID capture
    input wire logic id_sync,
    input wire logic [7:0] id_head_byte,
    input wire logic [7:0] id_cyl_byte,
    // Drive status lines
    input wire logic drv_ready,
    input wire logic drv_user,
    input wire logic drv_wprot,
    input wire logic drv_wfault,
    // Disk data stream (read side fills, write side drains)
    input wire logic disk_rd_valid,
    output logic disk_rd_ready,
    input wire logic [7:0] disk_rd_data,
    output logic disk_wr_byte_req,
    input wire logic disk_byte_due,
    // Configuration outputs to sequencers
    output logic fm_mode,
    output logic hard_disk,
    output logic crc_preset_ones,
    output logic crc_start,
    output logic [7:0] head_delay,
    output logic [31:0] step_period_cyc,
    output logic [15:0] step_pulse_cyc,
    output logic term_now,
    output logic term_after_sector
);
    // Whole register state as one struct
    typedef struct packed {
        logic strobe;
        logic rdy;
        logic [3:0] ptr;
        logic [7:0] mode;
        logic [7:0] tmask;
        logic [7:0] iflags;
        logic [1:0] tcode;
        logic [7:0] chip;
        logic [7:0] head;
        logic [7:0] cyl;
        logic [7:0] delay;
        logic [7:0] dout;
        logic oe_n;
        logic irq;
        logic [7:0] cmd;
        logic crc_go;
        logic stop_now;
        logic stop_sect;
        logic rd_rdy;
        logic [31:0] step;
        logic [15:0] pulse;
    } dcmsr_state_t;

    dcmsr_state_t st_q;
    dcmsr_state_t st_d;
    // FIFO drain side toward the host
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    logic fifo_in_ready;
    logic fifo_fill; // Byte accepted from the read stream

    // Read stream passes through the buffer; host reads of data pop it
    dcmsr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_fill),
        .in_ready(fifo_in_ready),
        .in_data(disk_rd_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Strobe edge is a falling transition of the active-low line
    logic acc;
    logic any_rst;
    logic [31:0] base;
    logic [2:0] rate;
    assign acc = st_q.strobe && !bus_strobe_n;
    assign any_rst = !rst_n_pin || reset_cmd;
    assign fifo_pop = acc && !cmd_sel && rd_wr && st_q.ptr == DCMSR_ADDR_DATA;
    assign rate = st_q.mode[2:0];
    // Only bytes offered while the registered ready stood are taken
    assign fifo_fill = disk_rd_valid && st_q.rd_rdy;

    // Next-state logic
    always_comb begin
        st_d = st_q;
        base = '0;
        st_d.strobe = bus_strobe_n;
        st_d.rdy = drv_ready;
        st_d.crc_go = 1'b0;
        // Ready drops a cycle after each byte: the flop cannot see the last free slot,
        // so half the rate is traded for never losing a byte
        st_d.rd_rdy = fifo_in_ready && !fifo_fill;
        st_d.oe_n = 1'b1;
        // Pointer load by the sequencer, auto-increment up to data
        if (ptr_load) begin
            st_d.ptr = ptr_value;
        end
        // Host access decode
        if (acc) begin
            if (cmd_sel && !rd_wr) begin
                // Command write clears done and status
                st_d.cmd = host_bus_lines_in;
                st_d.iflags[DCMSR_IF_DONE] = 1'b0;
                st_d.iflags[DCMSR_IF_BAD] = 1'b0;
                st_d.chip = DCMSR_RST_BYTE;
                st_d.stop_now = 1'b0;
                st_d.stop_sect = 1'b0;
            end else if (cmd_sel) begin
                // Status read: clears pending and ready change
                st_d.dout = {st_q.iflags[7:5], st_q.tcode, st_q.iflags[2:0]};
                st_d.oe_n = 1'b0;
                st_d.iflags[DCMSR_IF_PEND] = 1'b0;
                st_d.iflags[DCMSR_IF_RDYCHG] = 1'b0;
                st_d.irq = 1'b0;
            end else begin
                if (st_q.ptr != DCMSR_ADDR_DATA) begin
                    st_d.ptr = st_q.ptr + 4'h1;
                end
                if (!rd_wr) begin
                    unique case (st_q.ptr)
                        DCMSR_ADDR_MODE_CHIP: st_d.mode = host_bus_lines_in;
                        DCMSR_ADDR_TERM: st_d.tmask = host_bus_lines_in;
                        DCMSR_ADDR_DATA: st_d.delay = host_bus_lines_in;
                        default: ;
                    endcase
                end else begin
                    st_d.oe_n = 1'b0;
                    unique case (st_q.ptr)
                        DCMSR_ADDR_HEAD: st_d.dout = st_q.head;
                        DCMSR_ADDR_CYL: st_d.dout = st_q.cyl;
                        DCMSR_ADDR_MODE_CHIP: st_d.dout = {st_q.chip[7:2], drive_num};
                        DCMSR_ADDR_DATA: st_d.dout = fifo_data;
                        default: st_d.dout = 8'h00;
                    endcase
                end
            end
        end
        // DMA request tracks the byte buffer; cleared by the transfer
        st_d.iflags[DCMSR_IF_DMAR] = fifo_valid && !fifo_pop;
        // Byte due with no transfer taken counts as overrun
        if (disk_byte_due && (!fifo_in_ready || fifo_valid)) begin
            st_d.iflags[DCMSR_IF_OVR] = 1'b1;
        end
        // Ready line transition in either direction
        if (drv_ready != st_q.rdy) begin
            st_d.iflags[DCMSR_IF_RDYCHG] = 1'b1;
            if (st_q.tmask[DCMSR_TM_RDYCHG]) begin
                st_d.iflags[DCMSR_IF_PEND] = 1'b1;
                st_d.irq = 1'b1;
            end
        end
        // Chip status events
        if (retry_evt) st_d.chip[7] = 1'b1;
        if (ecc_fix_evt) st_d.chip[6] = 1'b1;
        if (crc_err_evt) st_d.chip[5] = 1'b1;
        st_d.chip[4] = ddm_seen;
        if (sync_err_evt) st_d.chip[3] = 1'b1;
        if (cmp_err_evt) st_d.chip[2] = 1'b1;
        if (sync_err_evt || cmp_err_evt) st_d.stop_now = 1'b1;
        // Mask-driven termination conditions
        if (st_q.tmask[DCMSR_TM_WP] && write_cmd && drv_wprot) begin
            st_d.stop_now = 1'b1;
        end
        if ((st_q.tmask[DCMSR_TM_DDM] && ddm_seen) ||
            (st_q.tmask[DCMSR_TM_USER] && drv_user) ||
            (st_q.tmask[DCMSR_TM_WF] && write_cmd && drv_wfault)) begin
            st_d.stop_sect = 1'b1;
        end
        // Done set: by sequencer, or at once, or at sector end; set wins over clear
        // Only the cycle an immediate stop appears counts, so a read can clear pending
        if (cmd_done || (st_d.stop_now && !st_q.stop_now) ||
            (st_q.stop_sect && sector_end)) begin
            st_d.iflags[DCMSR_IF_DONE] = 1'b1;
            st_d.tcode = term_code;
            if (st_q.tmask[DCMSR_TM_INT_DONE]) begin
                st_d.iflags[DCMSR_IF_PEND] = 1'b1;
                st_d.irq = 1'b1;
            end
        end
        // ID field sync: capture head and cylinder, CRC restarts
        if (id_sync) begin
            st_d.head[6:0] = id_head_byte[6:0];
            if (id_head_byte[7]) st_d.head[7] = 1'b1;
            st_d.iflags[DCMSR_IF_BAD] = id_head_byte[7];
            st_d.cyl = id_cyl_byte;
            st_d.crc_go = 1'b1;
        end
        // Step period: hard disk base doubling per code, floppy scaled
        if (rate == 3'h0) begin
            base = 32'(DCMSR_FAST_SEEK_CYC);
        end else begin
            base = 32'(DCMSR_STEP_MIN_CYC) << (rate - 3'h1);
        end
        if (!st_q.mode[DCMSR_MODE_HARD]) begin
            base = base * 32'(DCMSR_FLOPPY8_MUL);
        end
        st_d.step = st_q.mode[DCMSR_MODE_FM] ? base << 1 : base;
        st_d.pulse = 16'(DCMSR_PULSE_CYC);
        if (!st_q.mode[DCMSR_MODE_HARD]) begin
            st_d.pulse = 16'(DCMSR_PULSE_CYC * DCMSR_FLOPPY8_MUL);
        end
        if (st_q.mode[DCMSR_MODE_FM]) begin
            st_d.pulse = st_d.pulse << 1;
        end
        // Reset pin or reset command: bus idle, interrupt low, head flags cleared
        if (any_rst) begin
            st_d.irq = 1'b0;
            st_d.oe_n = 1'b1;
            st_d.iflags = DCMSR_RST_BYTE;
            st_d.chip = DCMSR_RST_BYTE;
            st_d.head = DCMSR_RST_BYTE;
            st_d.stop_now = 1'b0;
            st_d.stop_sect = 1'b0;
        end
    end

    // State register; synchronous reset to constants
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.strobe <= 1'b1;
            st_q.oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // All outputs come from the state flops
    assign host_bus_lines_out = st_q.dout;
    assign host_bus_lines_oe_n = st_q.oe_n;
    assign int_out = st_q.irq;
    assign disk_rd_ready = st_q.rd_rdy;
    assign disk_wr_byte_req = st_q.iflags[DCMSR_IF_DMAR];
    assign fm_mode = st_q.mode[DCMSR_MODE_FM];
    assign hard_disk = st_q.mode[DCMSR_MODE_HARD];
    assign crc_preset_ones = st_q.tmask[DCMSR_TM_CRC_PRESET];
    assign crc_start = st_q.crc_go;
    assign head_delay = st_q.delay;
    assign step_period_cyc = st_q.step;
    assign step_pulse_cyc = st_q.pulse;
    assign term_now = st_q.stop_now;
    assign term_after_sector = st_q.stop_sect;
endmodule

// Valid/ready FIFO with parameterised width and depth
module dcmsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // Storage array
    logic [WIDTH-1:0] mem_q [DEPTH];
    // Pointers and fill count
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update; simultaneous push and pop keeps count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// [rtl/dcmsr_pkg.sv]
// Package of register addresses, field positions and timing counts for the disk mode/status bank
package dcmsr_pkg;
    // Register pointer values (register file addresses)
    localparam logic [3:0] DCMSR_ADDR_HEAD = 4'h4;
    localparam logic [3:0] DCMSR_ADDR_CYL = 4'h5;
    localparam logic [3:0] DCMSR_ADDR_MODE_CHIP = 4'h8;
    localparam logic [3:0] DCMSR_ADDR_TERM = 4'h9;
    localparam logic [3:0] DCMSR_ADDR_DATA = 4'hA;
    // Mode register fields
    localparam int DCMSR_MODE_HARD = 7;
    localparam int DCMSR_MODE_FM = 4;
    // Termination mask fields
    localparam int DCMSR_TM_CRC_PRESET = 7;
    localparam int DCMSR_TM_INT_DONE = 5;
    localparam int DCMSR_TM_DDM = 4;
    localparam int DCMSR_TM_USER = 3;
    localparam int DCMSR_TM_WP = 2;
    localparam int DCMSR_TM_RDYCHG = 1;
    localparam int DCMSR_TM_WF = 0;
    // Interrupt flag fields
    localparam int DCMSR_IF_PEND = 7;
    localparam int DCMSR_IF_DMAR = 6;
    localparam int DCMSR_IF_DONE = 5;
    localparam int DCMSR_IF_RDYCHG = 2;
    localparam int DCMSR_IF_OVR = 1;
    localparam int DCMSR_IF_BAD = 0;
    // Termination codes
    localparam logic [1:0] DCMSR_TC_OK = 2'h0;
    localparam logic [1:0] DCMSR_TC_ID = 2'h1;
    localparam logic [1:0] DCMSR_TC_SEEK = 2'h2;
    localparam logic [1:0] DCMSR_TC_DATA = 2'h3;
    // Reset values
    localparam logic [7:0] DCMSR_RST_BYTE = 8'h00;
    // Step timing: hard disk, double density, in ns
    localparam int DCMSR_CLK_NS = 10;
    localparam int DCMSR_STEP_MIN_NS = 200000;
    localparam int DCMSR_FAST_SEEK_NS = 17600;
    localparam int DCMSR_FAST_REST_NS = 21800;
    localparam int DCMSR_PULSE_NS = 11200;
    localparam int DCMSR_STEP_MIN_CYC = DCMSR_STEP_MIN_NS / DCMSR_CLK_NS;
    localparam int DCMSR_FAST_SEEK_CYC = DCMSR_FAST_SEEK_NS / DCMSR_CLK_NS;
    localparam int DCMSR_FAST_REST_CYC = DCMSR_FAST_REST_NS / DCMSR_CLK_NS;
    localparam int DCMSR_PULSE_CYC = (DCMSR_PULSE_NS + DCMSR_CLK_NS - 1) / DCMSR_CLK_NS;
    // Floppy multipliers
    localparam int DCMSR_FLOPPY8_MUL = 10;
    localparam int DCMSR_FLOPPY5_MUL = 20;
endpackage

// [rtl/dcmsr_fifo.sv]
// Byte buffer of the disk unit; its module stands beside the register bank

// [bench/dcmsr_checker.sv]
// Port assertions for the disk mode/status register bank
`timescale 1ns/1ps
`default_nettype none
module dcmsr_checker
    import dcmsr_pkg::*;
(
    // Clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rst_n_pin,
    // Host bus
    input wire logic cmd_sel,
    input wire logic rd_wr,
    input wire logic bus_strobe_n,
    input wire logic host_bus_lines_oe_n,
    input wire logic int_out,
    // Events and configuration
    input wire logic cmd_done,
    input wire logic reset_cmd,
    input wire logic drv_ready,
    input wire logic id_sync,
    input wire logic crc_start,
    input wire logic fm_mode,
    input wire logic hard_disk,
    input wire logic [15:0] step_pulse_cyc
);
    logic rdy_q; // Last ready level
    logic [3:0] hist_q; // Recent interrupt causes, newest in bit 0
    // History lets interrupt timing float by a few pipeline cycles
    always_ff @(posedge clk) begin
        rdy_q <= drv_ready;
        hist_q <= {hist_q[2:0], cmd_done | (drv_ready ^ rdy_q)};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Read access taken on a falling strobe
    sequence rd_take_s;
        $fell(bus_strobe_n) && rd_wr;
    endsequence
    // Status read with no interrupt cause nearby
    sequence stat_rd_s;
        rd_take_s ##0 cmd_sel && !cmd_done && hist_q == 4'h0 && drv_ready == rdy_q;
    endsequence
    // Configuration held steady
    sequence cfg_s;
        ($stable(fm_mode) && $stable(hard_disk)) [*3];
    endsequence
    rd_drive_a: assert property (rd_take_s |=> !host_bus_lines_oe_n ##1 host_bus_lines_oe_n)
        else $error("read answer not driven for exactly one cycle");
    int_clr_a: assert property (stat_rd_s |=> !int_out)
        else $error("interrupt still high after status read");
    int_hold_a: assert property (int_out && rst_n_pin && !reset_cmd &&
        !($fell(bus_strobe_n) && cmd_sel && rd_wr) |=> int_out)
        else $error("interrupt dropped without status read");
    int_cause_a: assert property ($rose(int_out) |-> hist_q != 4'h0)
        else $error("interrupt rose without done or ready change");
    pin_rst_a: assert property (!rst_n_pin |=> !int_out && host_bus_lines_oe_n)
        else $error("reset pin did not idle outputs");
    cmd_rst_a: assert property (reset_cmd |=> !int_out && host_bus_lines_oe_n)
        else $error("reset command did not idle outputs");
    crc_go_a: assert property (id_sync |=> crc_start ##1 !crc_start)
        else $error("accumulation start not pulsed after sync");
    pulse_len_a: assert property (cfg_s ##0 step_pulse_cyc != 16'h0000 |->
        step_pulse_cyc == 16'(DCMSR_PULSE_CYC * (fm_mode ? 2 : 1) *
        (hard_disk ? 1 : DCMSR_FLOPPY8_MUL)))
        else $error("step pulse width wrong for density and drive");
endmodule
bind dcmsr_regs dcmsr_checker dcmsr_checker_i (
    .clk, .sys_rst, .rst_n_pin, .cmd_sel, .rd_wr, .bus_strobe_n, .host_bus_lines_oe_n,
    .int_out, .cmd_done, .reset_cmd, .drv_ready, .id_sync, .crc_start, .fm_mode,
    .hard_disk, .step_pulse_cyc
);
`default_nettype wire

// [bench/dcmsr_host.sv]
// Host processor model for the byte-wide command/register bus
`timescale 1ns/1ps
`default_nettype none
module dcmsr_host (
    // Clock
    input wire logic clk,
    // Bus toward the disk unit
    output logic cmd_sel,
    output logic rd_wr,
    output logic bus_strobe_n,
    output logic [7:0] host_bus_lines_in,
    input wire logic [7:0] host_bus_lines_out
);
    // Idle bus with strobe high
    initial begin
        cmd_sel = 1'b0;
        rd_wr = 1'b1;
        bus_strobe_n = 1'b1;
        host_bus_lines_in = 8'h00;
    end
    // One access: everything held until the answer edge has passed
    task automatic access(input logic cs, input logic rw, input logic [7:0] wd,
        output logic [7:0] rd);
        @(posedge clk);
        cmd_sel <= cs;
        rd_wr <= rw;
        host_bus_lines_in <= wd;
        bus_strobe_n <= 1'b0;
        // Taken at the next edge; the answer stands at the edge after it
        repeat (2) @(posedge clk);
        rd = host_bus_lines_out;
        bus_strobe_n <= 1'b1;
        // Released lines show the inverse, never a stale copy
        host_bus_lines_in <= ~wd;
    endtask
endmodule
`default_nettype wire

// [bench/disk_ctrl_mode_status_regs_test.sv]
// Self-checking bench for the disk mode/status register bank
`timescale 1ns/1ps
`default_nettype none
module disk_ctrl_mode_status_regs_test
    import dcmsr_pkg::*;
;
    // Clock, resets and host bus
    logic clk;
    logic sys_rst = 1'b1;
    logic rst_n_pin = 1'b1;
    wire logic cmd_sel, rd_wr, bus_strobe_n;
    wire logic [7:0] host_bus_lines_in;
    logic [7:0] host_bus_lines_out, rd, m, t, d, hb, head_delay;
    logic host_bus_lines_oe_n, int_out, fm_mode, hard_disk, crc_preset_ones, crc_start;
    logic term_now, term_after_sector, disk_rd_ready, disk_wr_byte_req;
    logic [31:0] step_period_cyc;
    logic [15:0] step_pulse_cyc;
    // Pulses: ptr load, id sync, done, reset cmd, byte due, sync, crc, retry
    logic [7:0] ev = 8'h00;
    logic [3:0] ptr_value = 4'h0;
    logic [1:0] term_code = 2'h0, drive_num = 2'h0;
    logic ddm_seen = 1'b0, write_cmd = 1'b0, drv_ready = 1'b0, drv_wprot = 1'b0;
    logic disk_rd_valid = 1'b0;
    logic [7:0] disk_rd_data = 8'h00, id_head_byte = 8'h00, id_cyl_byte = 8'h00;
    logic [31:0] seed = 32'h00015B62;
    logic [7:0] q[$];
    int failures = 0, check_count = 0, i;
    dcmsr_regs dcmsr_regs_i (
        .clk, .sys_rst, .rst_n_pin, .cmd_sel, .rd_wr, .bus_strobe_n, .host_bus_lines_in,
        .host_bus_lines_out, .host_bus_lines_oe_n, .int_out, .ptr_load(ev[7]), .ptr_value,
        .cmd_done(ev[5]), .term_code, .retry_evt(ev[0]), .ecc_fix_evt(1'b0),
        .crc_err_evt(ev[1]), .ddm_seen, .sync_err_evt(ev[2]), .cmp_err_evt(1'b0),
        .sector_end(1'b0), .write_cmd, .reset_cmd(ev[4]), .drive_num, .id_sync(ev[6]),
        .id_head_byte, .id_cyl_byte, .drv_ready, .drv_user(1'b0), .drv_wprot,
        .drv_wfault(1'b0), .disk_rd_valid, .disk_rd_ready, .disk_rd_data, .disk_wr_byte_req,
        .disk_byte_due(ev[3]), .fm_mode, .hard_disk, .crc_preset_ones, .crc_start,
        .head_delay, .step_period_cyc, .step_pulse_cyc, .term_now, .term_after_sector
    );
    dcmsr_host dcmsr_host_i (
        .clk, .cmd_sel, .rd_wr, .bus_strobe_n, .host_bus_lines_in, .host_bus_lines_out
    );
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Xorshift source, fixed start for repeatable runs
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    // Expected step period or pulse width in clocks
    function automatic logic [31:0] exp_time(input logic [7:0] v, input logic p);
        logic [31:0] s;
        if (p) s = 32'(DCMSR_PULSE_CYC);
        else if (v[2:0] == 3'h0) s = 32'(DCMSR_FAST_SEEK_CYC);
        else s = 32'(DCMSR_STEP_MIN_CYC) << (v[2:0] - 3'h1);
        if (!v[DCMSR_MODE_HARD]) s = s * 32'(DCMSR_FLOPPY8_MUL);
        if (v[DCMSR_MODE_FM]) s = s * 32'h2;
        return s;
    endfunction
    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // One-cycle pulse on the chosen event lines
    task automatic pulse(input logic [7:0] v);
        ev <= v;
        @(posedge clk);
        ev <= 8'h00;
    endtask
    // Register access through a freshly loaded pointer
    task automatic reg_acc(input logic [3:0] a, input logic rw, input logic [7:0] wd);
        ptr_value <= a;
        pulse(8'h80);
        dcmsr_host_i.access(1'b0, rw, wd, rd);
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles used
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("oe_n", 1, host_bus_lines_oe_n);
        // Mode, mask and delay via pointer increment; codes 000 and 001 first
        for (i = 0; i < 6; i++) begin
            m = rnd() & 8'hF7;
            if (i < 2) m[2:0] = 3'(i);
            t = rnd() & 8'hBF;
            d = rnd();
            reg_acc(DCMSR_ADDR_MODE_CHIP, 1'b0, m);
            dcmsr_host_i.access(1'b0, 1'b0, t, rd);
            dcmsr_host_i.access(1'b0, 1'b0, d, rd);
            chk("fm", m[4], fm_mode);
            chk("step", exp_time(m, 1'b0), step_period_cyc);
            chk("pulse", exp_time(m, 1'b1), 32'(step_pulse_cyc));
            chk("crc", t[7], crc_preset_ones);
            chk("delay", d, head_delay);
        end
        // Done interrupt with every termination code
        reg_acc(DCMSR_ADDR_TERM, 1'b0, 8'h22);
        for (i = 0; i < 5; i++) begin
            dcmsr_host_i.access(1'b1, 1'b0, rnd(), rd);
            dcmsr_host_i.access(1'b1, 1'b1, 8'h00, rd);
            chk("busy", 0, rd[DCMSR_IF_DONE]);
            if (i == 4) reg_acc(DCMSR_ADDR_TERM, 1'b0, 8'h00);
            term_code <= 2'(i);
            pulse(8'h20);
            repeat (5) @(posedge clk);
            chk("int", i < 4, int_out);
            dcmsr_host_i.access(1'b1, 1'b1, 8'h00, rd);
            if (i < 4) chk("stat", {8'hA0 | 8'(i << 3)}, rd & 8'hB8);
            chk("int_rd", 0, int_out);
        end
        // Ready change both ways, then reset command, then reset pin
        reg_acc(DCMSR_ADDR_TERM, 1'b0, 8'h02);
        for (i = 0; i < 3; i++) begin
            drv_ready <= ~drv_ready;
            repeat (6) @(posedge clk);
            chk("int_rdy", 1, int_out);
            if (i == 1) ev <= 8'h10;
            if (i == 2) rst_n_pin <= 1'b0;
            @(posedge clk);
            ev <= 8'h00;
            rst_n_pin <= 1'b1;
            @(posedge clk);
            chk("int_rst", i == 0, int_out);
            dcmsr_host_i.access(1'b1, 1'b1, 8'h00, rd);
            chk("rdy", i == 0, rd[DCMSR_IF_RDYCHG]);
            dcmsr_host_i.access(1'b1, 1'b1, 8'h00, rd);
            chk("rdy_clr", 0, rd[DCMSR_IF_RDYCHG]);
        end
        // ID capture; bad-sector flag must stick across a good sector
        for (i = 0; i < 2; i++) begin
            hb = rnd();
            hb[7] = (i == 0);
            id_head_byte <= hb;
            id_cyl_byte <= rnd();
            pulse(8'h40);
            reg_acc(DCMSR_ADDR_HEAD, 1'b1, 8'h00);
            chk("head", hb | 8'h80, rd);
            dcmsr_host_i.access(1'b0, 1'b1, 8'h00, rd);
            chk("cyl", id_cyl_byte, rd);
        end
        // Chip status flags
        drive_num <= 2'(rnd());
        ddm_seen <= 1'b1;
        pulse(8'h0F);
        reg_acc(DCMSR_ADDR_MODE_CHIP, 1'b1, 8'h00);
        chk("chip", 8'hB8 | 8'(drive_num), rd);
        // Write protect ends a write at once; a command first clears the old stop
        reg_acc(DCMSR_ADDR_TERM, 1'b0, 8'h04);
        dcmsr_host_i.access(1'b1, 1'b0, 8'h00, rd);
        chk("term_idle", 0, term_now);
        write_cmd <= 1'b1;
        drv_wprot <= 1'b1;
        repeat (4) @(posedge clk);
        chk("term", 1, term_now);
        // Fill the read FIFO with the host stalled, then drain in order
        disk_rd_valid <= 1'b1;
        disk_rd_data <= rnd();
        repeat (40) begin
            @(negedge clk);
            if (disk_rd_ready) q.push_back(disk_rd_data);
            @(posedge clk);
            if (disk_rd_ready) disk_rd_data <= rnd();
        end
        disk_rd_valid <= 1'b0;
        chk("fill", 16, q.size());
        chk("full", 0, disk_rd_ready);
        chk("dma_req", 1, disk_wr_byte_req);
        // A byte due while the buffer is full is an overrun
        pulse(8'h08);
        dcmsr_host_i.access(1'b1, 1'b1, 8'h00, rd);
        chk("ovr", 1, rd[DCMSR_IF_OVR]);
        chk("dmar", 1, rd[DCMSR_IF_DMAR]);
        reg_acc(DCMSR_ADDR_DATA, 1'b1, 8'h00);
        while (q.size() > 0) begin
            chk("data", q.pop_front(), rd);
            if (q.size() > 0) dcmsr_host_i.access(1'b0, 1'b1, 8'h00, rd);
        end
        chk("dma_idle", 0, disk_wr_byte_req);
        end_sim();
    end
endmodule
`default_nettype wire
